// ---- dv/rxsp_dsp_model.sv ----
// Behavioural DSP serial receiver that gathers the I and Q words.
`include "rxsp_regs.svh"
module rxsp_dsp_model (
  // Serial link from the port.
  input  wire logic rx_shift_clk,
  input  wire logic rx_frame_sync,
  input  wire logic inphase_serial_out,
  input  wire logic quadrature_serial_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [11:0] i_words[$];  // Words gathered from the data pin.
  logic [11:0] q_words[$];  // Words gathered from the second pin.
  logic [11:0] i_sr;        // Shift register for the data pin.
  logic [11:0] q_sr;        // Shift register for the second pin.
  int          cnt;         // Bits taken into the current word.
  bit          armed;       // A strobe has been seen since the flush.

  // Forget all gathered words, as a DSP does at the start of a session.
  function automatic void flush();
    i_words.delete();
    q_words.delete();
    armed = 1'b0;
    cnt = 0;
  endfunction

  // Bits are taken on the falling shift clock edge, MSB first. A strobe
  // restarts the count, so a data-less lead clock is thrown away; the
  // real receiver is no wiser, it simply counts edges.
  always @(negedge rx_shift_clk) begin
    if (armed) begin
      i_sr = {i_sr[10:0], inphase_serial_out};
      q_sr = {q_sr[10:0], quadrature_serial_out};
      cnt++;
      if (cnt == `RXSP_WORD_BITS) begin
        i_words.push_back(i_sr);
        q_words.push_back(q_sr);
        cnt = 0;
      end
    end
    if (rx_frame_sync === 1'b1) begin
      cnt = 0;
      armed = 1'b1;
    end
  end
endmodule

// ---- dv/rxsp_port_tb.sv ----
// Self-checking bench for the receive serial output port.
`include "rxsp_regs.svh"
`define RXSP_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module rxsp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // Design pins.
  logic        sys_clk;
  logic        rst;
  logic        clk_en;
  logic        channel_split;
  logic        rate_fast;
  logic        receive_powerdown_a;
  logic        receive_powerdown_b;
  logic [11:0] i_sample_in;
  logic [11:0] q_sample_in;
  logic        sample_take;
  logic        rx_shift_clk;
  logic        rx_frame_sync;
  logic        inphase_serial_out;
  logic        quadrature_serial_out;
  logic        rx_asleep;
  // Bench bookkeeping.
  int          num_errors = 0;  // Mismatches seen.
  int          compares = 0;    // Comparisons made.
  int          cyc = 0;         // Master cycles since start.
  int          takes = 0;       // Pairs taken in this test.
  int          last_take = 0;   // Cycle of the latest pair take.
  int          period = 0;      // Cycles between the last two takes.
  int          pair_n = 0;      // Index of the pair on the inputs.
  int          run = 0;         // Current run of high shift clock.
  int          max_run = 0;     // Longest high run once streaming.

  rxsp_port rxsp_port_i (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .channel_split(channel_split), .rate_fast(rate_fast),
    .receive_powerdown_a(receive_powerdown_a),
    .receive_powerdown_b(receive_powerdown_b),
    .i_sample_in(i_sample_in), .q_sample_in(q_sample_in),
    .sample_take(sample_take), .rx_shift_clk(rx_shift_clk),
    .rx_frame_sync(rx_frame_sync),
    .inphase_serial_out(inphase_serial_out),
    .quadrature_serial_out(quadrature_serial_out), .rx_asleep(rx_asleep)
  );

  rxsp_dsp_model rxsp_dsp_model_i (
    .rx_shift_clk(rx_shift_clk), .rx_frame_sync(rx_frame_sync),
    .inphase_serial_out(inphase_serial_out),
    .quadrature_serial_out(quadrature_serial_out)
  );

  // Sample values: distinct MSB halves make a reversed bit order show.
  function automatic logic [11:0] si(input int k);
    return 12'hA50 + 12'(k);
  endfunction
  function automatic logic [11:0] sq(input int k);
    return 12'h3C0 + 12'(k);
  endfunction
  // All link pins and the take strobe, for the freeze check.
  function automatic logic [4:0] pins();
    return {rx_shift_clk, rx_frame_sync, inphase_serial_out,
            quadrature_serial_out, sample_take};
  endfunction

  // Master clock at 25 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Feeds a fresh pair after each take and measures the link timing.
  // The wake-up run is left out of max_run by waiting for two takes.
  // A wake request seen while asleep restarts the per-test bookkeeping.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rx_asleep === 1'b1 && receive_powerdown_a === 1'b0) begin
      takes <= 0;
      pair_n <= 0;
      max_run <= 0;
      i_sample_in <= si(0);
      q_sample_in <= sq(0);
    end else if (sample_take === 1'b1) begin
      takes <= takes + 1;
      period <= cyc - last_take;
      last_take <= cyc;
      pair_n <= pair_n + 1;
      i_sample_in <= si(pair_n + 1);
      q_sample_in <= sq(pair_n + 1);
    end
    if (rx_shift_clk === 1'b1) run <= run + 1;
    else begin
      if (takes >= 2 && run > max_run) max_run <= run;
      run <= 0;
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Waits, under a bound, until n pairs have been taken.
  task automatic wait_takes(input int n);
    int t;
    for (t = 0; t < 3000 && takes < n; t++) @(posedge sys_clk);
    `RXSP_CHK("pair count", 1, int'(takes >= n))
  endtask

  // One wake, three IQ cycles and a sleep in the given arrangement.
  task automatic run_mode(input logic split, input logic fast);
    int          n;
    int          w;
    logic [11:0] ei[$];
    logic [11:0] eq[$];
    logic [4:0]  hold;
    @(posedge sys_clk);
    rxsp_dsp_model_i.flush();
    channel_split <= split;
    rate_fast <= fast;
    @(posedge sys_clk);
    receive_powerdown_a <= 1'b0;
    receive_powerdown_b <= 1'b0;
    w = fast ? `RXSP_WAKE_FAST : `RXSP_WAKE_SLOW;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (rx_frame_sync !== 1'b1 && n < 200);
    `RXSP_CHK("wake delay", w + 1, n)
    `RXSP_CHK("awake", 1'b0, rx_asleep)
    // A low clock enable holds every pin; it is done before the second
    // take so the measured period and high run stay untouched.
    @(posedge sys_clk);
    clk_en <= 1'b0;
    #1;
    hold = pins();
    repeat (8) @(posedge sys_clk);
    #1;
    `RXSP_CHK("frozen pins", hold, pins())
    @(posedge sys_clk);
    clk_en <= 1'b1;
    // One sleep pin alone must not stop the stream.
    wait_takes(2);
    receive_powerdown_a <= 1'b1;
    wait_takes(3);
    `RXSP_CHK("one pin sleep", 1'b0, rx_asleep)
    receive_powerdown_b <= 1'b1;
    for (n = 0; n < 400 && rx_asleep !== 1'b1; n++) @(posedge sys_clk);
    #1;
    `RXSP_CHK("asleep", 1'b1, rx_asleep)
    `RXSP_CHK("idle clock", 1'b1, rx_shift_clk)
    `RXSP_CHK("idle data", 1'b0, inphase_serial_out)
    // The cycle in progress at the request must have been finished.
    for (int k = 0; k < 3; k++) begin
      ei.push_back(si(k));
      eq.push_back(split ? sq(k) : 12'hFFF);
      if (!split) begin
        ei.push_back(sq(k));
        eq.push_back(12'h000);
      end else if (fast) begin
        ei.push_back(12'h000);
        eq.push_back(12'h000);
      end
    end
    `RXSP_CHK("word count", ei.size(), rxsp_dsp_model_i.i_words.size())
    for (int k = 0; k < ei.size(); k++) begin
      `RXSP_CHK("data word", ei[k], rxsp_dsp_model_i.i_words[k])
      `RXSP_CHK("flag word", eq[k], rxsp_dsp_model_i.q_words[k])
    end
    if (fast || split) `RXSP_CHK("pair period", 48, period)
    `RXSP_CHK("high run", fast ? 1 : (split ? 23 : 12), max_run)
    $display("test split %0d fast %0d done", split, fast);
  endtask

  // Reset with both sleep pins high, then all four arrangements.
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    channel_split = 1'b0;
    rate_fast = 1'b1;
    receive_powerdown_a = 1'b1;
    receive_powerdown_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `RXSP_CHK("reset asleep", 1'b1, rx_asleep)
    `RXSP_CHK("reset clock", 1'b1, rx_shift_clk)
    `RXSP_CHK("reset sync", 1'b0, rx_frame_sync)
    `RXSP_CHK("reset take", 1'b0, sample_take)
    $display("test reset done");
    for (int m = 0; m < 4; m++) run_mode(m[1], m[0]);
    report_and_stop();
  end

  // Watchdog: the tests need under a thousand cycles, this allows 20000.
  initial begin
    #(20000 * 40);
    num_errors++;
    report_and_stop();
  end
endmodule

// ---- logic/rxsp_pkg.sv ----
// Types shared by the receive serial output port modules.
`include "rxsp_regs.svh"
package rxsp_pkg;

  // Phases of the output sequencer.
  typedef enum logic [2:0] {
    RXSP_SLEEP,
    RXSP_WAKE,
    RXSP_LEAD,
    RXSP_BITS,
    RXSP_GAP
  } rxsp_state_t;

  // Complete state of the sequencer.
  typedef struct packed {
    rxsp_state_t st;
    logic [7:0]  cnt;
    logic [3:0]  bit_idx;
    logic        half;
    logic        word_q;
    logic        split;
    logic        fast;
    logic        shift_clk;
    logic        frame_sync;
    logic        asleep;
    logic        sample_take;
  } rxsp_seq_t;

  // Complete state of the word shifter.
  typedef struct packed {
    logic [`RXSP_WORD_BITS-1:0] i_word;
    logic [`RXSP_WORD_BITS-1:0] q_word;
    logic                       i_out;
    logic                       q_out;
  } rxsp_shift_t;

endpackage

// ---- logic/rxsp_port.sv ----
// Receive serial output port: sequences I/Q words out to a DSP.
// Behaviour
// R1: Mode pin selects two pins or one.
// R2: Fast rate: word every 24 master cycles; two pins here: a word every 48 (12 clocks, 12 data-less clocks).
// R3: Slow rate: word every 48 master cycles; one pin here: a word every 37 (strobe clock, 12 clocks, 11 high).
// R4: Both sleep inputs high: finish cycle, sleep.
// R5: One pin: 12-bit words plus I/Q flag.
// R6: One pin: I word precedes Q word.
// R7: One pin fast: 32-cycle wait, I first.
// R8: One pin fast: lead strobe, then last bits.
// R9: MSB first; DSP samples on falling edge.
// R10: One pin slow: 56-cycle wait, strobe, 12 clocks.
// R11: One pin slow: clock high 11 cycles.
// R12: Two pins: I on data, Q on flag.
// R13: Two pins fast: 32 wait, strobe, LSB strobes.
// R14: Two pins fast: 24 shift clocks per cycle.
// R15: Two pins slow: 56 wait, strobe, 12 clocks.
// R16: Two pins slow: clock high 22 cycles.
// R17: Shift clock runs at half master rate.
// R18: Flag high for I, low for Q.
`include "rxsp_regs.svh"
module rxsp_port #(
  parameter int WAKE_FAST = `RXSP_WAKE_FAST,
  parameter int WAKE_SLOW = `RXSP_WAKE_SLOW
) (
  // Master clock, reset and freeze.
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  // Configuration and sleep pins.
  input  wire logic                       channel_split,
  input  wire logic                       rate_fast,
  input  wire logic                       receive_powerdown_a,
  input  wire logic                       receive_powerdown_b,
  // Processed sample pair.
  input  wire logic [`RXSP_WORD_BITS-1:0] i_sample_in,
  input  wire logic [`RXSP_WORD_BITS-1:0] q_sample_in,
  output logic                            sample_take,
  // Serial link to the DSP.
  output logic                            rx_shift_clk,
  output logic                            rx_frame_sync,
  output logic                            inphase_serial_out,
  output logic                            quadrature_serial_out,
  // Status.
  output logic                            rx_asleep
);

  // Widths of the counter and phase bookkeeping are fixed, so the
  // wake delays must fit the 8-bit counter.
  if (WAKE_FAST < 1 || WAKE_FAST > 255 || WAKE_SLOW < 1 ||
      WAKE_SLOW > 255) begin : g_bad_wake
    $error("rxsp_port: wake delays must lie in 1 to 255");
  end
  // Word timing only closes if a word fits its divider.
  if (`RXSP_WORD_BITS * `RXSP_CYCLES_PER_BIT != `RXSP_DIV_FAST ||
      `RXSP_DIV_FAST * 2 != `RXSP_DIV_SLOW) begin : g_bad_div
    $error("rxsp_port: word length does not match the dividers");
  end

  rxsp_pkg::rxsp_seq_t s;        // Registered sequencer state.
  rxsp_pkg::rxsp_seq_t next_s;   // Next sequencer state.
  logic                end_word;  // Current word and its gap are done.
  logic                load;      // Take a fresh pair this edge.
  logic                sleep_req; // Both sleep inputs high.
  logic                running;   // Next cycle the shift clock is ~half, not held high.

  rxsp_shift_if cmd ();           // Commands to the shifter.

  // Master cycles to wait after wake-up for the given rate.
  function automatic logic [7:0] wake_len(input logic fast);
    return fast ? 8'(WAKE_FAST) : 8'(WAKE_SLOW);
  endfunction

  // Master cycles of gap after a word for the given arrangement.
  function automatic logic [7:0] gap_len(input logic split,
                                         input logic fast);
    logic [7:0] len;
    len = 8'h00;
    if (fast && split) begin
      len = 8'(`RXSP_GAP_FAST_DUAL); // R14
    end else if (!fast && split) begin
      len = 8'(`RXSP_GAP_SLOW_DUAL); // R16
    end else if (!fast) begin
      len = 8'(`RXSP_GAP_SLOW_SINGLE); // R11
    end
    return len;
  endfunction

  assign sleep_req = receive_powerdown_a & receive_powerdown_b;

  // Sequencer. Each bit spends one cycle with the shift clock high and
  // one with it low, so data set on the rising edge is stable at the
  // falling edge where the DSP samples it.
  always_comb begin
    next_s = s;
    next_s.sample_take = 1'b0;
    end_word = 1'b0;
    load = 1'b0;
    running = 1'b0;
    case (s.st)
      // Asleep: mode and rate are only looked at on waking, so a change
      // while awake takes effect after the next sleep.
      rxsp_pkg::RXSP_SLEEP: begin
        next_s.asleep = 1'b1;
        if (!receive_powerdown_a && !receive_powerdown_b) begin
          next_s.st = rxsp_pkg::RXSP_WAKE;
          next_s.cnt = 8'h00;
          next_s.asleep = 1'b0;
          next_s.split = channel_split; // R1
          next_s.fast = rate_fast; // R2 R3
        end
      end
      // Wake-up wait before the first shift clock.
      rxsp_pkg::RXSP_WAKE: begin
        if (sleep_req) begin
          next_s.st = rxsp_pkg::RXSP_SLEEP;
          next_s.asleep = 1'b1;
        end else if (s.cnt == wake_len(s.fast) - 8'h01) begin
          next_s.st = rxsp_pkg::RXSP_LEAD; // R7 R10 R13 R15
          next_s.half = 1'b0;
          next_s.word_q = 1'b0;
          load = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      // One shift clock that carries only the framing strobe.
      rxsp_pkg::RXSP_LEAD: begin
        if (!s.half) begin
          next_s.half = 1'b1;
        end else begin
          next_s.half = 1'b0;
          next_s.st = rxsp_pkg::RXSP_BITS;
          next_s.bit_idx = 4'h0;
        end
      end
      // Twelve data bits, MSB first.
      rxsp_pkg::RXSP_BITS: begin
        if (!s.half) begin
          next_s.half = 1'b1; // R17
        end else begin
          next_s.half = 1'b0;
          if (s.bit_idx != `RXSP_LAST_BIT) begin
            next_s.bit_idx = s.bit_idx + 4'h1; // R9
          end else if (gap_len(s.split, s.fast) != 8'h00) begin
            next_s.st = rxsp_pkg::RXSP_GAP;
            next_s.cnt = 8'h00;
          end else begin
            end_word = 1'b1;
          end
        end
      end
      // Gap after a word: the clock idles high, except at the fast rate
      // with two pins where it keeps running without data.
      rxsp_pkg::RXSP_GAP: begin
        next_s.half = (s.fast && s.split) ? ~s.half : 1'b0;
        if (s.cnt == gap_len(s.split, s.fast) - 8'h01) begin
          end_word = 1'b1;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end
      default: begin
        next_s = '0;
        next_s.st = rxsp_pkg::RXSP_SLEEP;
      end
    endcase
    // Word boundary: Q follows I on one pin; otherwise the IQ cycle is
    // complete and, apart from the wake-up wait, the sleep inputs are honoured only here.
    if (end_word) begin
      next_s.bit_idx = 4'h0;
      next_s.half = 1'b0;
      if (!s.split && !s.word_q) begin
        next_s.word_q = 1'b1; // R6
        next_s.st = s.fast ? rxsp_pkg::RXSP_BITS
                           : rxsp_pkg::RXSP_LEAD; // R8 R11
      end else if (sleep_req) begin
        next_s.st = rxsp_pkg::RXSP_SLEEP; // R4
        next_s.asleep = 1'b1;
        next_s.word_q = 1'b0;
      end else begin
        load = 1'b1;
        next_s.word_q = 1'b0; // R7
        next_s.st = s.fast ? rxsp_pkg::RXSP_BITS
                           : rxsp_pkg::RXSP_LEAD; // R13 R16
      end
    end
    next_s.sample_take = load;
    // Pin levels for the coming cycle, registered with the state.
    running = next_s.st == rxsp_pkg::RXSP_LEAD ||
              next_s.st == rxsp_pkg::RXSP_BITS ||
              (next_s.st == rxsp_pkg::RXSP_GAP && next_s.fast &&
               next_s.split);
    next_s.shift_clk = running ? ~next_s.half : 1'b1; // R17
    next_s.frame_sync = next_s.st == rxsp_pkg::RXSP_LEAD ||
                        (next_s.st == rxsp_pkg::RXSP_BITS &&
                         next_s.fast &&
                         next_s.bit_idx == `RXSP_LAST_BIT); // R8 R13
  end

  // Shifter commands follow the next state so data and clock line up.
  assign cmd.load = load;
  assign cmd.drive = next_s.st == rxsp_pkg::RXSP_BITS;
  assign cmd.bit_idx = next_s.bit_idx;
  assign cmd.sel_q = next_s.word_q;
  assign cmd.split = next_s.split;
  assign cmd.flag = ~next_s.word_q; // R18

  // State register; reset parks the port asleep with the clock high.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{st: rxsp_pkg::RXSP_SLEEP, cnt: 8'h00, bit_idx: 4'h0,
             half: 1'b0, word_q: 1'b0, split: 1'b0, fast: 1'b0,
             shift_clk: 1'b1, frame_sync: 1'b0, asleep: 1'b1,
             sample_take: 1'b0};
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Data pins come from the shifter's own flip-flops.
  rxsp_shifter u_shift (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .clk_en      (clk_en),
    .i_sample_in (i_sample_in),
    .q_sample_in (q_sample_in),
    .cmd         (cmd.shift),
    .i_pin       (inphase_serial_out),
    .q_pin       (quadrature_serial_out)
  );

  assign rx_shift_clk = s.shift_clk;
  assign rx_frame_sync = s.frame_sync;
  assign rx_asleep = s.asleep;
  assign sample_take = s.sample_take;

  // Checks run only on enabled cycles, since a frozen port holds still.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !clk_en);

  // A word on one pin at full speed spans its divider exactly.
  sequence one_word_s;
    s.st == rxsp_pkg::RXSP_BITS && s.bit_idx == 4'h0 && !s.half;
  endsequence

  sleep_idle_a: assert property ( // R4
    s.st == rxsp_pkg::RXSP_SLEEP |-> s.shift_clk && !s.frame_sync)
    else $error("shift clock not parked high in sleep");

  sleep_at_end_a: assert property ( // R4
    $rose(s.st == rxsp_pkg::RXSP_SLEEP) |->
      $past(s.st) == rxsp_pkg::RXSP_WAKE ||
      $past(s.word_q) || $past(s.split))
    else $error("sleep entered inside an IQ cycle");

  wake_delay_a: assert property ( // R7 R10 R13 R15
    $rose(s.st == rxsp_pkg::RXSP_LEAD) &&
      $past(s.st) == rxsp_pkg::RXSP_WAKE |->
      $past(s.cnt) == wake_len(s.fast) - 8'h01)
    else $error("first shift clock after wrong wake delay");

  lead_strobe_a: assert property ( // R8 R10
    s.st == rxsp_pkg::RXSP_LEAD && !s.half |->
      s.frame_sync ##1 s.frame_sync && !s.shift_clk ##1 !s.frame_sync)
    else $error("framing strobe missing on the lead clock");

  half_rate_a: assert property ( // R17
    s.st == rxsp_pkg::RXSP_BITS && !s.half |->
      s.shift_clk ##1 !s.shift_clk)
    else $error("shift clock not at half master rate");

  // Only the I word is watched: a Q word may be followed by sleep.
  fast_word_a: assert property ( // R2 R8
    s.st == rxsp_pkg::RXSP_BITS && s.bit_idx == 4'h0 && !s.half &&
      s.fast && !s.split && !s.word_q |->
      ##22 s.frame_sync ##1 s.frame_sync ##1 one_word_s)
    else $error("fast word is not 24 master cycles long");

  // The flag flip-flop is loaded at the same edge as the state.
  flag_level_a: assert property ( // R18
    s.st == rxsp_pkg::RXSP_BITS && !s.split |->
      quadrature_serial_out == !s.word_q)
    else $error("I/Q flag does not follow the word");

  // Each bit stands through both halves of its shift clock.
  bit_hold_a: assert property ( // R9
    s.st == rxsp_pkg::RXSP_BITS && !s.half |=>
      $stable(inphase_serial_out))
    else $error("data bit changed before the falling shift clock");

  // With no word to send the data pin rests low.
  data_idle_a: assert property ( // R4
    s.st == rxsp_pkg::RXSP_SLEEP |-> !inphase_serial_out)
    else $error("data pin not low while asleep");

  gap_high_a: assert property ( // R11 R16
    $fell(s.st == rxsp_pkg::RXSP_GAP) && !s.fast |->
      $past(s.cnt) == gap_len(s.split, s.fast) - 8'h01 &&
      $past(s.shift_clk))
    else $error("slow gap has wrong length or clock level");

  i_first_a: assert property ( // R6
    s.sample_take |-> !s.word_q)
    else $error("IQ cycle did not start with the I word");

endmodule

// ---- logic/rxsp_regs.svh ----
// Timing counts and field positions of the receive serial output port.
`ifndef RXSP_REGS_SVH
`define RXSP_REGS_SVH

// Width of one I or Q sample word, in bits.
`define RXSP_WORD_BITS 12
// Index of the least significant (last shifted) bit of a word.
`define RXSP_LAST_BIT 4'hB
// Master clock cycles from wake-up to the first shift clock, fast rate.
`define RXSP_WAKE_FAST 32
// Master clock cycles from wake-up to the first shift clock, slow rate.
`define RXSP_WAKE_SLOW 56
// Master clock divider that gives the fast word rate.
`define RXSP_DIV_FAST 24
// Master clock divider that gives the slow word rate.
`define RXSP_DIV_SLOW 48
// Master cycles of held-high shift clock after a word, slow one-pin.
`define RXSP_GAP_SLOW_SINGLE 11
// Master cycles of held-high shift clock after a pair, slow two-pin.
`define RXSP_GAP_SLOW_DUAL 22
// Master cycles of free-running, data-less shift clock, fast two-pin.
`define RXSP_GAP_FAST_DUAL 24
// Master cycles per shifted bit: the shift clock runs at half rate.
`define RXSP_CYCLES_PER_BIT 2

`endif

// ---- logic/rxsp_shift_if.sv ----
// Command bundle from the sequencer to the word shifter.
interface rxsp_shift_if;
  logic       load;     // Capture a fresh I/Q pair this edge.
  logic       drive;    // A data bit goes on the pins at this edge.
  logic [3:0] bit_idx;  // Bit position, 0 is the MSB.
  logic       sel_q;    // One-pin: the Q word is on the data pin.
  logic       split;    // Two-pin arrangement selected.
  logic       flag;     // One-pin: level for the I/Q flag pin.

  modport seq (output load, drive, bit_idx, sel_q, split, flag);
  modport shift (input load, drive, bit_idx, sel_q, split, flag);
endinterface

// ---- logic/rxsp_shifter.sv ----
// Word shifter: holds the I/Q pair and drives both serial data pins.
`include "rxsp_regs.svh"
module rxsp_shifter (
  // Clock, reset and freeze.
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  // Processed sample pair from the filters.
  input  wire logic [`RXSP_WORD_BITS-1:0] i_sample_in,
  input  wire logic [`RXSP_WORD_BITS-1:0] q_sample_in,
  // Commands from the sequencer.
  rxsp_shift_if.shift                     cmd,
  // Serial pins.
  output logic                            i_pin,
  output logic                            q_pin
);

  rxsp_pkg::rxsp_shift_t s;       // Registered state.
  rxsp_pkg::rxsp_shift_t next_s;  // Next state.
  logic [`RXSP_WORD_BITS-1:0] cur_i;  // I word seen this cycle.
  logic [`RXSP_WORD_BITS-1:0] cur_q;  // Q word seen this cycle.

  // Picks bit idx of a word counting from the MSB.
  function automatic logic pick(input logic [`RXSP_WORD_BITS-1:0] w,
                                input logic [3:0] idx);
    logic [3:0] pos;
    pos = 4'(`RXSP_WORD_BITS - 1) - idx;
    return w[pos];
  endfunction

  // Next state: on a load the fresh pair is used at once, so the first
  // bit of a back-to-back word is never taken from the stale pair.
  always_comb begin
    next_s = s;
    cur_i = cmd.load ? i_sample_in : s.i_word;
    cur_q = cmd.load ? q_sample_in : s.q_word;
    next_s.i_word = cur_i;
    next_s.q_word = cur_q;
    // Both words come from one pair, I shifted first on one pin.
    if (cmd.drive) begin
      next_s.i_out = cmd.sel_q ? pick(cur_q, cmd.bit_idx)
                               : pick(cur_i, cmd.bit_idx); // R1 R6 R9
    end else begin
      next_s.i_out = 1'b0;
    end
    // The second pin is either Q data or the I/Q flag.
    if (cmd.split) begin
      next_s.q_out = cmd.drive & pick(cur_q, cmd.bit_idx); // R12
    end else begin
      next_s.q_out = cmd.flag; // R5 R18
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign i_pin = s.i_out;
  assign q_pin = s.q_out;

endmodule
